// [shared/page_pkg.sv]
/*
 * Constants shared by the page select, decoder, decipher and prescaler logic.
 * Assumes a 10-bit serial address bus and 16-bit serial data words.
 */
package page_pkg;
   // Bus and field widths
   localparam int ABUS_W     = 10;
   localparam int DATA_W     = 16;
   localparam int PAGE_W     = 3;
   localparam int CORE_DIV_W = 6;
   localparam int OFS_DIV_W  = 8;
   localparam int REGION_W   = 4;
   localparam int REGION_LSB = 6;
   // Queued code word: both choices, address, data
   localparam int CODE_WORD_W = 2 + ABUS_W + DATA_W;
   localparam int FIFO_DEPTH  = 16;
   localparam int LEVEL_W     = 5;
   // Ready drops this close to full, covering the registered ready lag
   localparam logic [4:0] READY_LIMIT = 5'h0d;

   // Register addresses
   localparam logic [9:0] PAGE_SEL_ADDR = 10'h3ff;
   localparam logic [9:0] CORE_DIV_ADDR = 10'h1c0;
   localparam logic [9:0] OFS_DIV_ADDR  = 10'h1c4;
   localparam logic [15:0] REG_RST      = 16'h0000;

   // Page codes
   localparam logic [2:0] PAGE_NONE   = 3'h0;
   localparam logic [2:0] PAGE_CODE1  = 3'h1;
   localparam logic [2:0] PAGE_CODE2  = 3'h2;
   localparam logic [2:0] PAGE_BOTH   = 3'h3;
   localparam logic [2:0] PAGE_COMMON = 3'h4;
   localparam int         PAGE_TOP    = 2;

   // Common page areas, by address bits [9:6]
   localparam logic [3:0] REGION_DATA1 = 4'h0;
   localparam logic [3:0] REGION_DATA2 = 4'h1;
   localparam logic [3:0] REGION_CFG1  = 4'h4;
   localparam logic [3:0] REGION_CFG2  = 4'h5;
   localparam logic [3:0] REGION_IO    = 4'h6;
   localparam logic [3:0] REGION_MAIN  = 4'h7;
   localparam logic [3:0] REGION_DIAG  = 4'h8;

   // Operating mode thresholds on the core divisor
   localparam logic [5:0] SINGLE_MIN_DIV = 6'h01;
   localparam logic [5:0] DUAL_MIN_DIV   = 6'h03;

   // Keystream generator start value and feedback taps
   localparam logic [15:0] CIPHER_SEED = 16'h5a3c;
   localparam logic [15:0] CIPHER_TAPS = 16'hb400;
endpackage

// [verilog/word_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module word_fifo #(
   parameter int W     = 28,
   parameter int DEPTH = 16,
   parameter int LW    = 5
) (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   input  wire logic          in_valid_i,
   output wire logic          in_ready_o,
   input  wire logic [W-1:0]  in_data_i,
   output wire logic          out_valid_o,
   input  wire logic          out_ready_i,
   output wire logic [W-1:0]  out_data_o,
   output wire logic [LW-1:0] level_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];  // Word storage
   logic [AW-1:0] wr_ptr_r;     // Next slot to fill
   logic [AW-1:0] rd_ptr_r;     // Oldest slot
   logic [LW-1:0] count_r;      // Words held
   wire           push;
   wire           pop;

   // Honest flags straight from the count
   assign in_ready_o  = (count_r != LW'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem[rd_ptr_r];
   assign level_o     = count_r;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage is not reset; only pointers and count carry control state
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + AW'(push);
         rd_ptr_r <= rd_ptr_r + AW'(pop);
         count_r  <= count_r + LW'(push) - LW'(pop);
      end
   end
endmodule

// [verilog/tick_divider.sv]
/*
 * Programmable divider giving a one-cycle enable every div+1 cycles.
 * Assumes the divisor may change at any time; the count runs on against the new value.
 */
`timescale 1ns/100ps
module tick_divider #(
   parameter int W = 8
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] div_i,
   output wire logic         tick_o
);
   logic [W-1:0] cnt_r;   // Cycles since last tick
   logic         tick_r;  // Registered enable pulse
   wire          wrap;

   // Compare with >= so a lowered divisor never overshoots
   assign wrap   = (cnt_r >= div_i);
   assign tick_o = tick_r;

   // Count and pulse
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= wrap ? '0 : cnt_r + W'(1);
         tick_r <= wrap;
      end
   end
endmodule

// [verilog/spi_page_select_and_prescalers.sv]
/*
 * Page select register, area decoder, code download decipher and the
 * core / offset-compensation prescalers behind the serial interface.
 * Assumes the serial slave delivers each access as a one-cycle request
 * with address and data, only while bus_ready_o is high.
 */
`timescale 1ns/100ps
module spi_page_select_and_prescalers (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Serial access port
   input  wire logic        bus_req_i,
   input  wire logic        bus_wr_i,
   input  wire logic [9:0]  a_bus_i,
   input  wire logic [15:0] bus_wdata_i,
   output logic             bus_ready_o,
   output logic             bus_rvalid_o,
   output logic [15:0]      bus_rdata_o,
   // Area selects
   output logic [2:0]       channel1_area_selects_o,
   output logic [2:0]       channel2_area_selects_o,
   output logic             main_sel_o,
   output logic             io_sel_o,
   output logic             diag_sel_o,
   // Deciphered code memory write port
   output logic             code_wr_o,
   input  wire logic        code_ready_i,
   output logic             code_mem1_choice_o,
   output logic             code_mem2_choice_o,
   output logic [9:0]       code_addr_o,
   output logic [15:0]      code_data_o,
   // Prescaled enables and mode permissions
   output logic             prescaled_core_clk_o,
   output logic             offset_comp_clk_o,
   output logic             single_core_ok_o,
   output logic             dual_core_ok_o,
   output logic             flag_drive_ok_o
);
   // Registers; all on the undivided system clock
   logic [2:0]  page_r;
   logic [5:0]  core_divisor_field_r;  // Core divisor
   logic [7:0]  offset_divisor_field_r;// Offset divisor
   logic [15:0] keystream_r;           // Decipher state
   logic        restart_pend_r;        // Restart awaiting drain
   logic        ready_r;
   logic        rvalid_r;
   logic [15:0] rdata_r;
   logic [2:0]  ch1_sel_r;
   logic [2:0]  ch2_sel_r;
   logic        main_sel_r;
   logic        io_sel_r;
   logic        diag_sel_r;
   logic        code_wr_r;
   logic        choice1_r;
   logic        choice2_r;
   logic [9:0]  code_addr_r;
   logic [15:0] code_data_r;
   logic        single_ok_r;
   logic        dual_ok_r;

   // Access decode
   wire         take       = bus_req_i & ready_r;
   wire         wr_take    = take & bus_wr_i;
   wire         rd_take    = take & ~bus_wr_i;
   wire         page_hit   = (a_bus_i == page_pkg::PAGE_SEL_ADDR);
   wire         page_wr    = wr_take & page_hit;
   wire         common     = (page_r == page_pkg::PAGE_COMMON);
   wire         core_hit   = common & (a_bus_i == page_pkg::CORE_DIV_ADDR);
   wire         ofs_hit    = common & (a_bus_i == page_pkg::OFS_DIV_ADDR);
   wire [3:0]   region     = a_bus_i[page_pkg::REGION_LSB +: page_pkg::REGION_W];
   wire         code1_page = (page_r == page_pkg::PAGE_CODE1);
   wire         code2_page = (page_r == page_pkg::PAGE_CODE2);
   wire         both_page  = (page_r == page_pkg::PAGE_BOTH);
   wire         code_page  = code1_page | code2_page | both_page;

   // Page codes with the top bit set collapse to the common page
   wire [2:0]   page_wval  = bus_wdata_i[page_pkg::PAGE_TOP] ?
                             page_pkg::PAGE_COMMON : bus_wdata_i[2:0];

   // Area decoding; page 000 and any other page miss leave all low
   wire         area_ok    = take & ~page_hit;
   wire         com_ok     = area_ok & common;
   wire         c1_code    = area_ok & code1_page & ~bus_wr_i;
   wire         c2_code    = area_ok & code2_page & ~bus_wr_i;
   wire [2:0]   ch1_nxt    = {com_ok & (region == page_pkg::REGION_CFG1),
                              c1_code,
                              com_ok & (region == page_pkg::REGION_DATA1)};
   wire [2:0]   ch2_nxt    = {com_ok & (region == page_pkg::REGION_CFG2),
                              c2_code,
                              com_ok & (region == page_pkg::REGION_DATA2)};
   wire         main_nxt   = com_ok & (region == page_pkg::REGION_MAIN);
   wire         io_nxt     = com_ok & (region == page_pkg::REGION_IO);
   wire         diag_nxt   = com_ok & (region == page_pkg::REGION_DIAG);

   // Code writes go to the queue; reads in page 011 are dropped
   wire         push       = area_ok & code_page & bus_wr_i;
   wire         push_m1    = code1_page | both_page;
   wire         push_m2    = code2_page | both_page;
   wire [27:0]  push_word  = {push_m1, push_m2, a_bus_i, bus_wdata_i};

   // Queue drain side
   wire         q_valid;
   wire         q_in_ready;
   wire [27:0]  q_word;
   wire [4:0]   q_level;
   wire         out_free   = ~code_wr_r | code_ready_i;
   wire         pop        = q_valid & out_free;
   wire         drained    = ~q_valid & ~code_wr_r;
   wire         restart    = restart_pend_r & drained;

   // Every word leaves through the keystream XOR, no bypass path
   wire [15:0]  plain      = q_word[15:0] ^ keystream_r;
   wire         ks_fb      = ^(keystream_r & page_pkg::CIPHER_TAPS);
   wire [15:0]  ks_step    = {keystream_r[14:0], ks_fb};

   // Read mux; reserved bits read zero
   wire [15:0]  rd_mux     = page_hit ? {13'h0000, page_r} :
                             core_hit ? {10'h000, core_divisor_field_r} :
                             {8'h00, offset_divisor_field_r};
   wire         rd_own     = rd_take & (page_hit | core_hit | ofs_hit);

   // Restart request; a new page write wins over the drain clear
   wire         pend_nxt   = page_wr | (restart_pend_r & ~drained);
   // Accept only with room for one more word behind a stale ready
   wire         ready_nxt  = (q_level < page_pkg::READY_LIMIT) & ~pend_nxt;

   // Download queue between the serial side and the code memories
   word_fifo #(
      .W     (page_pkg::CODE_WORD_W),
      .DEPTH (page_pkg::FIFO_DEPTH),
      .LW    (page_pkg::LEVEL_W)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (push),
      .in_ready_o  (q_in_ready),
      .in_data_i   (push_word),
      .out_valid_o (q_valid),
      .out_ready_i (out_free),
      .out_data_o  (q_word),
      .level_o     (q_level)
   );

   // Core clock enable, divisor+1
   tick_divider #(
      .W (page_pkg::CORE_DIV_W)
   ) u_core_div (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .div_i     (core_divisor_field_r),
      .tick_o    (prescaled_core_clk_o)
   );

   // Offset compensation clock enable, divisor+1
   tick_divider #(
      .W (page_pkg::OFS_DIV_W)
   ) u_ofs_div (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .div_i     (offset_divisor_field_r),
      .tick_o    (offset_comp_clk_o)
   );

   // Page select register, writable from any page
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         page_r <= page_pkg::PAGE_NONE;
      end else if (page_wr) begin
         page_r <= page_wval;
      end
   end

   // Divider registers; only the divisor bits are stored
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         core_divisor_field_r   <= page_pkg::REG_RST[5:0];
         offset_divisor_field_r <= page_pkg::REG_RST[7:0];
      end else if (wr_take) begin
         if (core_hit) begin
            core_divisor_field_r <= bus_wdata_i[5:0];
         end
         if (ofs_hit) begin
            offset_divisor_field_r <= bus_wdata_i[7:0];
         end
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rvalid_r <= 1'b0;
         rdata_r  <= page_pkg::REG_RST;
      end else begin
         rvalid_r <= rd_own;
         rdata_r  <= rd_own ? rd_mux : page_pkg::REG_RST;
      end
   end

   // Registered area selects, one cycle per access
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ch1_sel_r  <= 3'h0;
         ch2_sel_r  <= 3'h0;
         main_sel_r <= 1'b0;
         io_sel_r   <= 1'b0;
         diag_sel_r <= 1'b0;
      end else begin
         ch1_sel_r  <= ch1_nxt;
         ch2_sel_r  <= ch2_nxt;
         main_sel_r <= main_nxt;
         io_sel_r   <= io_nxt;
         diag_sel_r <= diag_nxt;
      end
   end

   // Restart flag and serial ready
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         restart_pend_r <= 1'b0;
         ready_r        <= 1'b0;
      end else begin
         restart_pend_r <= pend_nxt;
         ready_r        <= ready_nxt;
      end
   end

   // Keystream: restart waits for the queue to drain so that words
   // sent under the old page keep their own stream position
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         keystream_r <= page_pkg::CIPHER_SEED;
      end else if (restart) begin
         keystream_r <= page_pkg::CIPHER_SEED;
      end else if (pop) begin
         keystream_r <= ks_step;
      end
   end

   // Code write stage, held until the memory takes it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         code_wr_r   <= 1'b0;
         choice1_r   <= 1'b0;
         choice2_r   <= 1'b0;
         code_addr_r <= 10'h000;
         code_data_r <= page_pkg::REG_RST;
      end else if (out_free) begin
         code_wr_r   <= q_valid;
         choice1_r   <= q_valid & q_word[27];
         choice2_r   <= q_valid & q_word[26];
         code_addr_r <= q_word[25:16];
         code_data_r <= plain;
      end
   end

   // Mode permissions from the core divisor
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         single_ok_r <= 1'b0;
         dual_ok_r   <= 1'b0;
      end else begin
         single_ok_r <= (core_divisor_field_r >= page_pkg::SINGLE_MIN_DIV);
         dual_ok_r   <= (core_divisor_field_r >= page_pkg::DUAL_MIN_DIV);
      end
   end

   assign bus_ready_o             = ready_r;
   assign bus_rvalid_o            = rvalid_r;
   assign bus_rdata_o             = rdata_r;
   assign channel1_area_selects_o = ch1_sel_r;
   assign channel2_area_selects_o = ch2_sel_r;
   assign main_sel_o              = main_sel_r;
   assign io_sel_o                = io_sel_r;
   assign diag_sel_o              = diag_sel_r;
   assign code_wr_o               = code_wr_r;
   assign code_mem1_choice_o      = choice1_r;
   assign code_mem2_choice_o      = choice2_r;
   assign code_addr_o             = code_addr_r;
   assign code_data_o             = code_data_r;
   assign single_core_ok_o        = single_ok_r;
   assign flag_drive_ok_o         = single_ok_r;
   assign dual_core_ok_o          = dual_ok_r;

   // Helper: cycles since the last core tick
   logic [7:0] gap_r;
   logic       gap_ok_r;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         gap_r    <= 8'h00;
         gap_ok_r <= 1'b0;
      end else if (prescaled_core_clk_o) begin
         gap_r    <= 8'h00;
         gap_ok_r <= ~(wr_take & core_hit);
      end else begin
         gap_r    <= gap_r + 8'h01;
         gap_ok_r <= gap_ok_r & ~(wr_take & core_hit);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   page_norm_a: assert property (page_wr && bus_wdata_i[2] |=> page_r == 3'h4)
      else $error("page top bit did not collapse to common");
   page_any_a: assert property (page_wr |=> page_r == $past(page_wval))
      else $error("page register write lost");
   idle_page_a: assert property (page_r == 3'h0 |=>
      !(|ch1_sel_r || |ch2_sel_r || main_sel_r || io_sel_r || diag_sel_r || q_level > $past(q_level)))
      else $error("access acted while no page selected");
   both_code_a: assert property (push |-> push_word[27:26] == {page_r[0], page_r[1]})
      else $error("code write sent to wrong memories");
   queue_room_a: assert property (push |-> q_in_ready)
      else $error("code word pushed into full queue");
   one_area_a: assert property ($onehot0({ch1_sel_r, ch2_sel_r, main_sel_r, io_sel_r, diag_sel_r}))
      else $error("more than one area select");
   dual_mode_a: assert property ($stable(core_divisor_field_r) [*2] |->
      dual_core_ok_o == (core_divisor_field_r >= 6'h03))
      else $error("dual core permission wrong");
   restart_ks_a: assert property (page_wr |-> ##[1:40] keystream_r == page_pkg::CIPHER_SEED)
      else $error("keystream not restarted");
   decipher_a: assert property (pop && out_free |=> code_data_o == $past(plain))
      else $error("code data not deciphered");
   core_gap_a: assert property (prescaled_core_clk_o && gap_ok_r |->
      gap_r == {2'b00, core_divisor_field_r})
      else $error("core tick spacing wrong");
   ofs_zero_a: assert property ((offset_divisor_field_r == 8'h00) [*2] |-> offset_comp_clk_o)
      else $error("offset tick missing at divisor zero");

   both_write_c: cover property (code_wr_o && code_mem1_choice_o && code_mem2_choice_o);
   restart_c: cover property (page_wr ##[1:20] restart);
   queue_full_c: cover property (!q_in_ready);
   dual_c: cover property (dual_core_ok_o && prescaled_core_clk_o);
endmodule

// [tb/host_master.sv]
/*
 * Behavioural serial master that stands in for the external controller.
 * Assumes the bench calls access() from one process at a time.
 */
`timescale 1ns/100ps
module host_master (
   input  wire logic        clk_sys_i,
   input  wire logic        bus_ready_i,
   output logic             bus_req_o,
   output logic             bus_wr_o,
   output logic [9:0]       a_bus_o,
   output logic [15:0]      bus_wdata_o
);
   // Idle bus at time zero
   initial begin
      bus_req_o = 1'b0;
      bus_wr_o = 1'b0;
      a_bus_o = 10'h000;
      bus_wdata_o = 16'h0000;
   end

   // One access: raise after a falling edge, hold until an edge with ready high
   task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] d,
                         output logic ok);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      bus_req_o = 1'b1;
      bus_wr_o = wr;
      a_bus_o = a;
      bus_wdata_o = d;
      // Ready is registered, so its value between edges decides the next edge
      while (bus_ready_i !== 1'b1 && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      @(posedge clk_sys_i);
      ok = (n < 200);
      @(negedge clk_sys_i);
      bus_req_o = 1'b0;
      // Released lines show the inverse so stale values cannot pass
      a_bus_o = ~a;
      bus_wdata_o = ~d;
   endtask
endmodule

// [tb/test_spi_page_select_and_prescalers.sv]
/*
 * Self-checking bench: register model, area decoder, decipher restart, prescalers.
 * Assumes page_pkg and host_master are compiled first.
 */
`timescale 1ns/100ps
module test_spi_page_select_and_prescalers;
   logic        clk_sys_i = 1'b0;    // System clock
   logic        rst_i     = 1'b1;    // Synchronous reset
   logic        bus_req, bus_wr, bus_ready, bus_rvalid, code_wr, m1, m2;
   logic        core_tick, ofs_tick, single_ok, dual_ok, flag_ok, ok;
   logic        code_ready = 1'b1;   // Code memory acceptance, randomly stalled
   logic [9:0]  a_bus, code_addr;
   logic [15:0] bus_wdata, bus_rdata, code_data, rd_s;
   logic [15:0] ks;                  // Model keystream, restarted per page write
   logic [2:0]  ch1, ch2;
   logic        main_sel, io_sel, diag_sel, rv_s, diff;
   logic [8:0]  sel_s;               // Selects seen in the answer window
   logic [27:0] code_q[$];           // Accepted code words {m1,m2,addr,data}
   logic [15:0] saved[4], wd[4];
   logic [9:0]  wa[4];
   int          miscompares = 0;
   int          n_tests = 0;
   int          page_m, p, n;        // Model page and measured periods
   logic [3:0]  rg[7] = '{page_pkg::REGION_DATA1, page_pkg::REGION_DATA2,
                          page_pkg::REGION_CFG1, page_pkg::REGION_CFG2,
                          page_pkg::REGION_IO, page_pkg::REGION_MAIN, page_pkg::REGION_DIAG};
   logic [8:0]  ex[7] = '{9'h040, 9'h008, 9'h100, 9'h020, 9'h002, 9'h004, 9'h001};
   int          od[3] = '{0, 8, 255};

   always #2 clk_sys_i = ~clk_sys_i;

   host_master u_host_master (.clk_sys_i(clk_sys_i), .bus_ready_i(bus_ready),
      .bus_req_o(bus_req), .bus_wr_o(bus_wr), .a_bus_o(a_bus), .bus_wdata_o(bus_wdata));

   spi_page_select_and_prescalers u_spi_page_select_and_prescalers (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_req_i(bus_req), .bus_wr_i(bus_wr),
      .a_bus_i(a_bus), .bus_wdata_i(bus_wdata), .bus_ready_o(bus_ready),
      .bus_rvalid_o(bus_rvalid), .bus_rdata_o(bus_rdata),
      .channel1_area_selects_o(ch1), .channel2_area_selects_o(ch2),
      .main_sel_o(main_sel), .io_sel_o(io_sel), .diag_sel_o(diag_sel),
      .code_wr_o(code_wr), .code_ready_i(code_ready), .code_mem1_choice_o(m1),
      .code_mem2_choice_o(m2), .code_addr_o(code_addr), .code_data_o(code_data),
      .prescaled_core_clk_o(core_tick), .offset_comp_clk_o(ofs_tick),
      .single_core_ok_o(single_ok), .dual_core_ok_o(dual_ok), .flag_drive_ok_o(flag_ok));

   // Code memory side: random stalls, accepted words go to the queue
   always @(negedge clk_sys_i) code_ready <= ($urandom % 3) != 0;
   always @(posedge clk_sys_i) begin
      if (code_wr === 1'b1 && code_ready === 1'b1) begin
         code_q.push_back({m1, m2, code_addr, code_data});
      end
   end

   task automatic finish_test;
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_val(input logic [27:0] got, input logic [27:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         miscompares++;
         $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask

   // One access, then gather read answer and selects over three samples
   task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
      rv_s = 1'b0;
      rd_s = 16'h0000;
      sel_s = 9'h000;
      u_host_master.access(wr, a, d, ok);
      if (!ok) chk_cnt(0, 1);
      if (!ok) finish_test();
      for (int i = 0; i < 3; i++) begin
         if (bus_rvalid === 1'b1) begin
            rv_s = 1'b1;
            rd_s = bus_rdata;
         end
         sel_s = sel_s | {ch1, ch2, main_sel, io_sel, diag_sel};
         if (i < 2) @(negedge clk_sys_i);
      end
   endtask

   // Cycles between two ticks; 300 means no tick came
   task automatic period(input logic ofs, output int q);
      n = 0;
      while ((ofs ? ofs_tick : core_tick) !== 1'b1 && n < 300) begin
         @(negedge clk_sys_i);
         n++;
      end
      @(negedge clk_sys_i);
      q = 1;
      while ((ofs ? ofs_tick : core_tick) !== 1'b1 && q < 300) begin
         @(negedge clk_sys_i);
         q++;
      end
   endtask

   initial begin
      void'($urandom(32'h7fe2_6eaa));
      repeat (12) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      // Reset value, and no page selected refuses other registers
      bus(1'b0, page_pkg::PAGE_SEL_ADDR, 16'h0000);
      chk_val({rv_s, rd_s}, {1'b1, page_pkg::REG_RST});
      bus(1'b0, page_pkg::CORE_DIV_ADDR, 16'h0000);
      chk_val({rv_s, sel_s}, 28'h0);
      // Every page code, with random reserved bits
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, page_pkg::PAGE_SEL_ADDR, {13'($urandom), 3'(c)});
         page_m = c[2] ? 4 : c;
         bus(1'b0, page_pkg::PAGE_SEL_ADDR, 16'h0000);
         chk_val({rv_s, rd_s}, {1'b1, 16'(page_m)});
      end
      // Core divisor: readback, mode permissions, tick period
      for (int dv = 0; dv < 5; dv++) begin
         bus(1'b1, page_pkg::CORE_DIV_ADDR, 16'hffc0 | 16'(dv));
         bus(1'b0, page_pkg::CORE_DIV_ADDR, 16'h0000);
         chk_val(rd_s, 28'(dv));
         chk_val({single_ok, flag_ok, dual_ok}, {dv >= 1, dv >= 1, dv >= 3});
         period(1'b0, p);
         chk_cnt(p, dv + 1);
      end
      foreach (od[i]) begin
         bus(1'b1, page_pkg::OFS_DIV_ADDR, 16'hff00 | 16'(od[i]));
         bus(1'b0, page_pkg::OFS_DIV_ADDR, 16'h0000);
         chk_val(rd_s, 28'(od[i]));
         period(1'b1, p);
         chk_cnt(p, od[i] + 1);
      end
      // Common page areas
      foreach (rg[i]) begin
         bus(1'b0, {rg[i], 6'h03}, 16'h0000);
         chk_val(sel_s, ex[i]);
      end
      // Same enciphered words in pages 1, 2 and 3, page write between
      foreach (wa[w]) begin
         wa[w] = 10'($urandom % 1023);
         wd[w] = 16'($urandom);
      end
      diff = 1'b0;
      for (int pg = 1; pg < 4; pg++) begin
         bus(1'b1, page_pkg::PAGE_SEL_ADDR, 16'(pg));
         // The host may not read code in page 3, so it reads the page register there
         bus(1'b0, pg == 3 ? page_pkg::PAGE_SEL_ADDR : 10'h005, 16'h0000);
         chk_val({rv_s, sel_s}, pg == 1 ? 28'h080 : pg == 2 ? 28'h010 : 28'h200);
         code_q.delete();
         foreach (wa[w]) begin
            u_host_master.access(1'b1, wa[w], wd[w], ok);
            if (!ok) chk_cnt(0, 1);
         end
         for (n = 0; n < 100 && code_q.size() < 4; n++) @(negedge clk_sys_i);
         chk_cnt(code_q.size(), 4);
         ks = page_pkg::CIPHER_SEED;
         for (int w = 0; w < code_q.size() && w < 4; w++) begin
            chk_val(code_q[w][27:16], {pg[0], pg[1], wa[w]});
            chk_val(code_q[w][15:0], wd[w] ^ ks);
            ks = {ks[14:0], ^(ks & page_pkg::CIPHER_TAPS)};
            if (pg == 1) saved[w] = code_q[w][15:0];
            if (pg == 1) diff = diff | (code_q[w][15:0] !== wd[w]);
            else chk_val(code_q[w][15:0], saved[w]);
         end
      end
      chk_val(diff, 1'b1);
      // No page: code writes are dropped
      bus(1'b1, page_pkg::PAGE_SEL_ADDR, 16'h0000);
      code_q.delete();
      bus(1'b1, 10'h005, 16'h1234);
      repeat (10) @(negedge clk_sys_i);
      chk_cnt(code_q.size(), 0);
      finish_test();
   end
endmodule
